// >>> rtl/sfd_device.sv
// Purpose: scanner device end: serial load, display latches, digit scan
// Assumes: every link line is asynchronous to core_clk
// Notes:   a link line counts as changed once sync stages 2 and 3 agree
`timescale 1ns/1ns
`include "sfd_map.svh"

module sfd_device
  import sfd_pkg::*;
(
  input  wire logic core_clk,
  input  wire logic reset,
  sfd_link_if.dev   link,
  output sfd_pkg::sfd_seg_t seg_out,
  output logic      dp_out,
  output logic [3:0] digit_sel,
  output logic      cascade_active
);
  import sfd_pkg::*;
  localparam int P_DATA = 0;
  localparam int P_SCLK = 1;
  localparam int P_WIN  = 2;
  localparam int P_OSC  = 3;

  logic [3:0]            pin_raw;
  logic [3:0]            s1_r;
  logic [3:0]            s2_r;
  logic [3:0]            s3_r;
  logic [3:0]            lvl_r;
  logic [3:0]            lvl_d_r;
  logic                  sclk_fall;
  logic                  win_fall;
  logic                  win_rise;
  logic                  osc_rise;
  logic [`SFD_WORD_BITS-1:0] shift_r;
  logic [`SFD_CNT_W-1:0] cnt_r;
  logic [`SFD_DIG_BITS-1:0] digits_r;
  sfd_code_t             dp_r;
  logic [1:0]            scan_r;
  logic [1:0]            scan_nxt;
  sfd_code_t             code_nxt;
  logic                  cascade;

  assign pin_raw = {link.scan_osc_in, link.load_window_n, link.sclk, link.sdata};

  always_ff @(posedge core_clk) begin
    if (reset) begin
      s1_r <= `SFD_PIN_RST;
      s2_r <= `SFD_PIN_RST;
      s3_r <= `SFD_PIN_RST;
    end else begin
      s1_r <= pin_raw;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // Stages 2 and 3 must agree, which rejects a one-cycle glitch
  always_ff @(posedge core_clk) begin
    if (reset) begin
      lvl_r   <= `SFD_PIN_RST;
      lvl_d_r <= `SFD_PIN_RST;
    end else begin
      lvl_d_r <= lvl_r;
      for (int i = 0; i < 4; i++) begin
        if (s2_r[i] == s3_r[i]) begin
          lvl_r[i] <= s3_r[i];
        end
      end
    end
  end

  assign sclk_fall = lvl_d_r[P_SCLK] & ~lvl_r[P_SCLK];
  assign win_fall  = lvl_d_r[P_WIN] & ~lvl_r[P_WIN];
  assign win_rise  = ~lvl_d_r[P_WIN] & lvl_r[P_WIN];
  assign osc_rise  = ~lvl_d_r[P_OSC] & lvl_r[P_OSC];

  always_ff @(posedge core_clk) begin
    if (reset) begin
      shift_r <= '0;
    end else if (sclk_fall && !lvl_r[P_WIN]) begin
      shift_r <= {shift_r[`SFD_WORD_BITS-2:0], lvl_r[P_DATA]};
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      cnt_r <= '0;
    end else if (win_fall) begin
      cnt_r <= '0;
    end else if (sclk_fall && !lvl_r[P_WIN] && cnt_r != `SFD_CNT_FULL) begin
      cnt_r <= cnt_r + 1'b1;
    end
  end

  // point code is the oldest nibble
  always_ff @(posedge core_clk) begin
    if (reset) begin
      digits_r <= '0;
      dp_r     <= '0;
    end else if (win_rise) begin
      digits_r <= shift_r[`SFD_DIG_BITS-1:0];
      // A sixteen-pulse load leaves the point latch as it was
      if (cnt_r == `SFD_CNT_FULL) begin
        dp_r <= shift_r[`SFD_DP_MSB:`SFD_DP_LSB];
      end
    end
  end

  assign cascade        = dp_r == `SFD_CASCADE_CODE;
  assign cascade_active = cascade;

  // scan rate set by the host
  assign scan_nxt = osc_rise ? scan_r + 2'd1 : scan_r;
  assign code_nxt = digits_r[4'(4'd15 - 4'(scan_nxt) * 4'd4) -: 4];

  always_ff @(posedge core_clk) begin
    if (reset) begin
      scan_r    <= '0;
      digit_sel <= `SFD_DIGIT_RST;
    end else begin
      scan_r    <= scan_nxt;
      // Selects and segments change on the same edge, so no overlap
      digit_sel <= 4'h1 << scan_nxt;
    end
  end

  function automatic sfd_seg_t seg_decode(input sfd_code_t c);
    // Bit order g f e d c b a, high lights the segment
    case (c)
      4'h0: seg_decode = 7'h3f;
      4'h1: seg_decode = 7'h06;
      4'h2: seg_decode = 7'h5b;
      4'h3: seg_decode = 7'h4f;
      4'h4: seg_decode = 7'h66;
      4'h5: seg_decode = 7'h6d;
      4'h6: seg_decode = 7'h7d;
      4'h7: seg_decode = 7'h07;
      4'h8: seg_decode = 7'h7f;
      4'h9: seg_decode = 7'h6f;
      4'ha: seg_decode = 7'h77;
      4'hb: seg_decode = 7'h7c;
      4'hc: seg_decode = 7'h39;
      4'hd: seg_decode = 7'h5e;
      4'he: seg_decode = 7'h79;
      default: seg_decode = 7'h71;
    endcase
  endfunction

  always_ff @(posedge core_clk) begin
    if (reset) begin
      seg_out <= '0;
    end else begin
      seg_out <= seg_decode(code_nxt);
    end
  end

  // cascade persists until a new point code
  always_ff @(posedge core_clk) begin
    if (reset) begin
      dp_out <= 1'b0;
    end else if (cascade) begin
      dp_out <= shift_r[`SFD_DP_MSB];
    end else begin
      dp_out <= dp_r[2'd3 - scan_nxt];
    end
  end
endmodule

// >>> rtl/sfd_host.sv
// Purpose: host end: FIFO of load requests and serial word generator
// Assumes: user pushes sfd_req_t words; device samples on sclk fall
// Notes:   sclk and scan oscillator are divided down from core_clk
`timescale 1ns/1ns
`include "sfd_map.svh"

module sfd_fifo #(
  parameter int WIDTH = 21,
  parameter int DEPTH = `SFD_FIFO_DEPTH
) (
  input  wire logic             core_clk,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
    $error("sfd_fifo: DEPTH must be a power of two, at least 2");
  end
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW:0]      wr_r;
  logic [AW:0]      rd_r;
  logic             push;
  logic             pop;

  assign in_ready  = (wr_r - rd_r) != (AW+1)'(DEPTH);
  assign out_valid = wr_r != rd_r;
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  assign out_data  = mem_r[rd_r[AW-1:0]];

  always_ff @(posedge core_clk) begin
    if (push) begin
      mem_r[wr_r[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      wr_r <= '0;
      rd_r <= '0;
    end else begin
      if (push) begin
        wr_r <= wr_r + 1'b1;
      end
      if (pop) begin
        rd_r <= rd_r + 1'b1;
      end
    end
  end
endmodule

module sfd_host
  import sfd_pkg::*;
#(
  parameter int SCAN_HALF_CYC = `SFD_SCAN_HALF_CYC
) (
  input  wire logic core_clk,
  input  wire logic reset,
  sfd_link_if.host  link,
  input  wire sfd_pkg::sfd_req_t req_data,
  input  wire logic req_valid,
  output logic      req_ready,
  output logic      busy
);
  import sfd_pkg::*;
  localparam int HALF = `SFD_SCLK_HALF_CYC;
  localparam int LEAD = `SFD_ENB_LEAD_CYC;
  localparam int LAG  = `SFD_ENB_LAG_CYC;
  if (SCAN_HALF_CYC < 1 || SCAN_HALF_CYC > 24'hffffff) begin : g_chk
    $error("sfd_host: SCAN_HALF_CYC out of range");
  end

  sfd_req_t    q_data;
  logic        q_valid;
  logic        q_ready;
  sfd_hstate_t st_r;
  logic [15:0] tmr_r;
  logic [19:0] word_r;
  logic [4:0]  left_r;
  logic [23:0] osc_cnt_r;
  logic        osc_r;
  logic        sclk_r;
  logic        sdata_r;
  logic        win_n_r;
  logic        tmr_done;

  sfd_fifo #(.WIDTH(21), .DEPTH(`SFD_FIFO_DEPTH)) u_fifo (
    .core_clk  (core_clk),
    .reset     (reset),
    .in_data   (req_data),
    .in_valid  (req_valid),
    .in_ready  (req_ready),
    .out_data  (q_data),
    .out_valid (q_valid),
    .out_ready (q_ready)
  );

  assign q_ready         = st_r == SFD_IDLE;
  assign tmr_done        = tmr_r == 16'h0000;
  assign busy            = st_r != SFD_IDLE;
  assign link.sclk       = sclk_r;
  assign link.sdata      = sdata_r;
  assign link.load_window_n = win_n_r;
  assign link.scan_osc_in   = osc_r;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      osc_cnt_r <= '0;
      osc_r     <= 1'b0;
    end else if (osc_cnt_r == 24'(SCAN_HALF_CYC - 1)) begin
      osc_cnt_r <= '0;
      osc_r     <= ~osc_r;
    end else begin
      osc_cnt_r <= osc_cnt_r + 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      st_r    <= SFD_IDLE;
      tmr_r   <= '0;
      word_r  <= '0;
      left_r  <= '0;
      sclk_r  <= 1'b1;
      sdata_r <= 1'b0;
      win_n_r <= 1'b1;
    end else begin
      if (!tmr_done) begin
        tmr_r <= tmr_r - 1'b1;
      end
      case (st_r)
        SFD_IDLE: begin
          if (q_valid) begin
            word_r  <= q_data[19:0];
            left_r  <= q_data[20] ? `SFD_CNT_FULL : `SFD_CNT_DIGITS;
            win_n_r <= 1'b0;
            tmr_r   <= 16'(LEAD);
            st_r    <= SFD_LEAD;
          end
        end
        SFD_LEAD: begin
          if (tmr_done) begin
            sdata_r <= (left_r == `SFD_CNT_FULL) ? word_r[19] : word_r[15];
            if (left_r != `SFD_CNT_FULL) begin
              word_r <= {word_r[15:0], 4'h0};
            end
            tmr_r   <= 16'(HALF);
            st_r    <= SFD_HIGH;
          end
        end
        SFD_HIGH: begin
          if (tmr_done) begin
            sclk_r <= 1'b0;
            tmr_r  <= 16'(HALF);
            left_r <= left_r - 1'b1;
            word_r <= {word_r[18:0], 1'b0};
            st_r   <= SFD_LOW;
          end
        end
        SFD_LOW: begin
          if (tmr_done) begin
            sclk_r <= 1'b1;
            if (left_r == 5'h00) begin
              tmr_r <= 16'(LAG);
              st_r  <= SFD_LAG;
            end else begin
              sdata_r <= word_r[19];
              tmr_r   <= 16'(HALF);
              st_r    <= SFD_HIGH;
            end
          end
        end
        SFD_LAG: begin
          if (tmr_done) begin
            win_n_r <= 1'b1;
            tmr_r   <= 16'(HALF);
            st_r    <= SFD_GAP;
          end
        end
        SFD_GAP: begin
          if (tmr_done) begin
            st_r <= SFD_IDLE;
          end
        end
        default: begin
          st_r <= SFD_IDLE;
        end
      endcase
    end
  end
endmodule

// >>> rtl/sfd_link_if.sv
// Purpose: serial link between host and scanner device
// Assumes: all lines driven by the host
// Notes:   no two-way pins on this link
`timescale 1ns/1ns
interface sfd_link_if;
  logic sclk;
  logic sdata;
  logic load_window_n;
  logic scan_osc_in;
  modport host (output sclk, output sdata, output load_window_n, output scan_osc_in);
  modport dev  (input  sclk, input  sdata, input  load_window_n, input  scan_osc_in);
endinterface

// >>> rtl/sfd_map.svh
// Purpose: constants for the serial four-digit scanner and its host
// Assumes: core_clk at 100 MHz
// Notes:   timing counts derive from times in ns or Hz
`ifndef SFD_MAP_SVH
`define SFD_MAP_SVH

`define SFD_WORD_BITS      20
`define SFD_DIG_BITS       16
`define SFD_DP_MSB         19
`define SFD_DP_LSB         16
`define SFD_CASCADE_CODE   4'hf
`define SFD_CNT_W          5
`define SFD_CNT_FULL       5'h14
`define SFD_CNT_DIGITS     5'h10
`define SFD_PIN_RST        4'h6
`define SFD_DIGIT_RST      4'h1

`define SFD_CLK_HZ         100000000
`define SFD_CLK_NS         10
`define SFD_SCLK_HALF_NS   2000
`define SFD_SCLK_HALF_CYC  ((`SFD_SCLK_HALF_NS + `SFD_CLK_NS - 1) / `SFD_CLK_NS)
`define SFD_ENB_LEAD_NS    200
`define SFD_ENB_LEAD_CYC   ((`SFD_ENB_LEAD_NS + `SFD_CLK_NS - 1) / `SFD_CLK_NS)
`define SFD_ENB_LAG_NS     200
`define SFD_ENB_LAG_CYC    ((`SFD_ENB_LAG_NS + `SFD_CLK_NS - 1) / `SFD_CLK_NS)
`define SFD_SCAN_HZ        400
`define SFD_SCAN_MIN_HZ    200
`define SFD_SCAN_MAX_HZ    800
`define SFD_SCAN_HALF_CYC  (`SFD_CLK_HZ / (2 * `SFD_SCAN_HZ))
`define SFD_FIFO_DEPTH     16

`endif

// >>> rtl/sfd_pkg.sv
// Purpose: shared types of the scanner and its host
// Assumes: nothing beyond the map header
// Notes:   numbers live in sfd_map.svh
package sfd_pkg;
  typedef logic [3:0]  sfd_code_t;
  typedef logic [6:0]  sfd_seg_t;
  // Host request: use_dp, dp code, four digit codes (first digit highest)
  typedef logic [20:0] sfd_req_t;
  typedef enum logic [2:0] {
    SFD_IDLE,
    SFD_LEAD,
    SFD_HIGH,
    SFD_LOW,
    SFD_LAG,
    SFD_GAP
  } sfd_hstate_t;
endpackage

// >>> sim/serial_four_digit_led_scanner_tb.sv
// Purpose: host and scanner device joined over the link
// Assumes: scan half period shortened to 8 cycles
// Notes:   a 20-bit load takes about 8300 cycles, so loads are few
`timescale 1ns/1ns
module serial_four_digit_led_scanner_tb;
  import sfd_pkg::*;
  localparam int HALF = 8;
  localparam sfd_seg_t SEG [16] = '{7'h3f, 7'h06, 7'h5b, 7'h4f, 7'h66, 7'h6d, 7'h7d, 7'h07,
                                    7'h7f, 7'h6f, 7'h77, 7'h7c, 7'h39, 7'h5e, 7'h79, 7'h71};
  logic        core_clk;
  logic        reset;
  sfd_req_t    req_data;
  logic        req_valid;
  logic        req_ready;
  logic        busy;
  sfd_seg_t    seg_out;
  logic        dp_out;
  logic [3:0]  digit_sel;
  logic        cascade_active;
  int          mismatches;
  int          num_checks;

  sfd_link_if i_sfd_link_if ();
  sfd_host #(.SCAN_HALF_CYC(HALF)) i_sfd_host (.core_clk(core_clk), .reset(reset),
    .link(i_sfd_link_if), .req_data(req_data), .req_valid(req_valid),
    .req_ready(req_ready), .busy(busy));
  sfd_device i_sfd_device (.core_clk(core_clk), .reset(reset), .link(i_sfd_link_if),
    .seg_out(seg_out), .dp_out(dp_out), .digit_sel(digit_sel),
    .cascade_active(cascade_active));
  sfd_link_checker #(.SCAN_HALF_CYC(HALF)) i_sfd_link_checker (.core_clk(core_clk),
    .reset(reset), .sclk(i_sfd_link_if.sclk), .sdata(i_sfd_link_if.sdata),
    .load_window_n(i_sfd_link_if.load_window_n), .scan_osc_in(i_sfd_link_if.scan_osc_in));

  task automatic test_done();
    if (mismatches == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk_vec(input string nm, input logic [20:0] exp, input logic [20:0] got);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("FAIL %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic chk_bit(input string nm, input logic exp, input logic got);
    chk_vec(nm, {20'h0, exp}, {20'h0, got});
  endtask
  // Valid stays up so a second push lands on the very next edge
  task automatic push(input sfd_req_t w);
    @(posedge core_clk);
    req_data  <= w;
    req_valid <= 1'h1;
  endtask
  task automatic settle();
    int quiet;
    @(posedge core_clk);
    req_valid <= 1'h0;
    quiet = 0;
    for (int i = 0; i < 40000 && quiet < 8; i++) begin
      @(negedge core_clk);
      quiet = (busy === 1'h0) ? quiet + 1 : 0;
    end
    chk_bit("host idle", 1'h1, quiet >= 8);
  endtask
  task automatic load(input sfd_req_t w);
    push(w);
    settle();
  endtask
  task automatic show(input logic [15:0] d, input logic [3:0] dp, input logic use_dp);
    for (int k = 0; k < 4; k++) begin
      for (int i = 0; i < 200 && digit_sel !== 4'h1 << k; i++) @(negedge core_clk);
      chk_vec("digit_sel", 4'h1 << k, digit_sel);
      chk_vec("seg_out", SEG[d[15-4*k -: 4]], seg_out);
      if (use_dp) chk_bit("dp_out", dp[3-k], dp_out);
    end
  endtask

  initial begin
    core_clk = 1'h0;
    forever #5 core_clk = ~core_clk;
  end
  initial begin
    #(95000 * 10);
    mismatches++;
    test_done();
  end

  initial begin
    reset = 1'h1;
    req_data = '0;
    req_valid = 1'h0;
    mismatches = 0;
    num_checks = 0;
    repeat (10) @(posedge core_clk);
    reset <= 1'h0;
    @(negedge core_clk);
    chk_vec("digit_sel", 4'h1, digit_sel);
    chk_vec("seg_out", 7'h0, seg_out);
    chk_bit("cascade_active", 1'h0, cascade_active);
    chk_bit("req_ready", 1'h1, req_ready);
    // Host pulls the first word at once, so sixteen pushed leave room for one
    for (int i = 0; i < 17; i++) push({1'h0, 4'h0, 16'(i)});
    @(negedge core_clk);
    chk_bit("req_ready", 1'h1, req_ready); // fifteen queued
    push(21'h0);
    @(negedge core_clk);
    chk_bit("req_ready", 1'h0, req_ready); // sixteen queued, full
    chk_bit("busy", 1'h1, busy); // first load running
    chk_bit("load_window_n", 1'h0, i_sfd_link_if.load_window_n); // window open
    @(posedge core_clk);
    req_valid <= 1'h0;
    @(negedge core_clk);
    chk_bit("req_ready", 1'h0, req_ready); // extra word refused
    // Reset in mid-load must flush the queue and close the window
    @(posedge core_clk);
    reset <= 1'h1;
    repeat (3) @(posedge core_clk);
    reset <= 1'h0;
    repeat (2) @(negedge core_clk);
    chk_bit("req_ready", 1'h1, req_ready); // queue emptied
    chk_bit("busy", 1'h0, busy); // no load restarted
    chk_bit("load_window_n", 1'h1, i_sfd_link_if.load_window_n); // window closed
    chk_bit("sclk", 1'h1, i_sfd_link_if.sclk); // clock idle high
    chk_vec("digit_sel", 4'h1, digit_sel); // scan restarts
    chk_bit("cascade_active", 1'h0, cascade_active); // latch cleared
    load({1'h1, 4'ha, 16'h1234});
    show(16'h1234, 4'ha, 1'h1); // word order
    push({1'h1, 4'h5, 16'h5678});
    @(posedge core_clk);
    req_valid <= 1'h0;
    repeat (4000) @(negedge core_clk);
    chk_bit("load_window_n", 1'h0, i_sfd_link_if.load_window_n);
    show(16'h1234, 4'ha, 1'h1); // old data while shifting
    settle();
    show(16'h5678, 4'h5, 1'h1); // new data after close
    load({1'h0, 4'h0, 16'h9abc});
    show(16'h9abc, 4'h5, 1'h1); // short load keeps point
    load({1'h0, 4'h0, 16'hdef0});
    show(16'hdef0, 4'h5, 1'h1); // all codes decoded
    load({1'h1, 4'hf, 16'h0123});
    chk_bit("cascade_active", 1'h1, cascade_active); // cascade code
    chk_bit("dp_out", 1'h1, dp_out); // shift output on point pin
    show(16'h0123, 4'h0, 1'h0); // digits still scanned
    // Short load keeps the ones code; pin then shows old shift bit 3
    load({1'h0, 4'h0, 16'h4567});
    chk_bit("cascade_active", 1'h1, cascade_active); // cascade kept
    chk_bit("dp_out", 1'h0, dp_out); // pin follows shift register
    push({1'h1, 4'hf, 16'h2468});
    push({1'h1, 4'h3, 16'h1357});
    @(posedge core_clk);
    req_valid <= 1'h0;
    repeat (12000) @(negedge core_clk);
    chk_bit("load_window_n", 1'h0, i_sfd_link_if.load_window_n); // second load
    chk_bit("cascade_active", 1'h1, cascade_active); // ones word keeps chain
    settle();
    chk_bit("cascade_active", 1'h0, cascade_active); // chain left
    show(16'h1357, 4'h3, 1'h1); // point back on its digit
    test_done();
  end
endmodule

// >>> sim/sfd_link_checker.sv
// Purpose: wire-level checks on the serial link
// Assumes: host drives every line from core_clk registers
// Notes:   sclk phase and window holds are measured by small saturating counters
`timescale 1ns/1ns
module sfd_link_checker #(
  parameter int SCAN_HALF_CYC = 125000
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic sclk,
  input wire logic sdata,
  input wire logic load_window_n,
  input wire logic scan_osc_in
);
  logic [7:0]  ph_cnt;
  logic [7:0]  lo_cnt;
  logic [4:0]  falls;
  logic [31:0] osc_cnt;
  logic        osc_seen;
  logic        sclk_q;
  logic        osc_q;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  always_ff @(posedge core_clk) begin
    sclk_q <= sclk;
    osc_q  <= scan_osc_in;
  end
  // Saturate so idle stretches never wrap into a short phase
  always_ff @(posedge core_clk) begin
    if (reset) ph_cnt <= 8'hff;
    else if (sclk != sclk_q) ph_cnt <= 8'h0;
    else if (ph_cnt != 8'hff) ph_cnt <= ph_cnt + 8'h1;
  end
  always_ff @(posedge core_clk) begin
    if (load_window_n) lo_cnt <= 8'h0;
    else if (lo_cnt != 8'hff) lo_cnt <= lo_cnt + 8'h1;
  end
  always_ff @(posedge core_clk) begin
    if (load_window_n) falls <= 5'h0;
    else if (sclk_q && !sclk) falls <= falls + 5'h1;
  end
  // First half period after reset may be short, so it is skipped
  always_ff @(posedge core_clk) begin
    if (reset) osc_seen <= 1'h0;
    else if (scan_osc_in != osc_q) osc_seen <= 1'h1;
    if (scan_osc_in != osc_q) osc_cnt <= 32'h0;
    else osc_cnt <= osc_cnt + 32'h1;
  end

  fall_in_window_a: assert property ($fell(sclk) |-> !load_window_n)
    else $error("sclk fell with the load window closed");
  phase_length_a: assert property ($changed(sclk) |-> ph_cnt >= 8'hc7)
    else $error("sclk phase shorter than 200 cycles");
  lead_time_a: assert property ($fell(sclk) |-> lo_cnt >= 8'h14)
    else $error("first sclk fall too soon after window opened");
  lag_time_a: assert property ($rose(load_window_n) |-> sclk && ph_cnt >= 8'h13)
    else $error("window closed too soon after last sclk rise");
  bit_count_a: assert property ($rose(load_window_n) |-> falls == 5'h10 || falls == 5'h14)
    else $error("load did not carry 16 or 20 clock pulses");
  data_hold_a: assert property (!sclk |-> $stable(sdata))
    else $error("sdata moved while sclk low");
  idle_high_a: assert property (load_window_n |-> sclk)
    else $error("sclk not idle high outside a load");
  scan_half_a: assert property ($changed(scan_osc_in) && osc_seen |->
                                osc_cnt == SCAN_HALF_CYC - 1)
    else $error("scan clock half period wrong");
endmodule
